//--- core/pcfg_defs.vh
// Register map, reset values and field positions of the port pad configuration block.
`ifndef PCFG_DEFS_VH
`define PCFG_DEFS_VH

// ==========================================================================
// Register word indexes (Avalon word address; byte address is four times).
// ==========================================================================
`define PCFG_IDX_PULLDOWN_TWO 5'h00
`define PCFG_IDX_OPEN_DRAIN 5'h01
`define PCFG_IDX_PULLHIGH_TWO 5'h02
`define PCFG_IDX_IRQ_MASK_TWO 5'h03
`define PCFG_IDX_IRQ_MASK_ONE 5'h04
`define PCFG_IDX_P5_DATA 5'h05
`define PCFG_IDX_P6_DATA 5'h06
`define PCFG_IDX_P7_DATA 5'h07
`define PCFG_IDX_P8_DATA 5'h08
`define PCFG_IDX_P5_DIR 5'h09
`define PCFG_IDX_P6_DIR 5'h0A
`define PCFG_IDX_P7_DIR 5'h0B
`define PCFG_IDX_P8_DIR 5'h0C
`define PCFG_IDX_WAKE_CTRL 5'h0D
`define PCFG_IDX_CORE_CMD 5'h0E
`define PCFG_IDX_EVT_STATUS 5'h0F
`define PCFG_IDX_EVT_MASK 5'h10

// ==========================================================================
// Reset values.
// ==========================================================================
`define PCFG_RST_PULLDOWN 8'hFF
`define PCFG_RST_OPEN_DRAIN 8'h00
`define PCFG_RST_PULLHIGH 8'hFF
`define PCFG_RST_IRQ_MASK 8'h00
`define PCFG_RST_WAKE_CTRL 8'h00

// ==========================================================================
// Field positions and masks.
// ==========================================================================
`define PCFG_MASK_TWO_USED 8'hBF
`define PCFG_MASK_ONE_USED 8'h7F
`define PCFG_BIT_INPUT_CHANGE_IE 1
`define PCFG_BIT_WAKE_ENABLE 6
`define PCFG_BIT_CMD_ENI 0
`define PCFG_BIT_CMD_GLOBAL_IRQ_OFF_INSTR 1
`define PCFG_BIT_CMD_SLEEP 2
`define PCFG_BIT_EVT_CHANGE 0
`define PCFG_BIT_EVT_WAKE 1
`define PCFG_EVT_USED 8'h03

// ==========================================================================
// Interrupt vector of the port 6 input change.
// ==========================================================================
`define PCFG_ICHG_VECTOR 12'h006

`endif

//--- core/pcfg_port.v
// One bidirectional tri-state port: data and direction registers and pad drive.
`include "pcfg_defs.vh"

module pcfg_port #(
    parameter WIDTH = 8
) (
    // Clock and reset.
    input wire clk,
    input wire rst_b,
    // Register writes.
    input wire wr_data_en,
    input wire wr_dir_en,
    input wire [WIDTH-1:0] wdata,
    // Open-drain selection per pin, zero for ports without it.
    input wire [WIDTH-1:0] od,
    // Register contents and registered pad drive.
    output reg [WIDTH-1:0] data,
    output reg [WIDTH-1:0] dir,
    output reg [WIDTH-1:0] pad_out,
    output reg [WIDTH-1:0] pad_oe
);

    // ======================================================================
    // Data and direction registers.
    // ======================================================================
    // A direction bit of one makes the pin an input; reset leaves every pin
    // as a high-impedance input so nothing fights the board at power-up.
    always @(posedge clk) begin
        if (!rst_b) begin
            data <= {WIDTH{1'b0}};
            dir <= {WIDTH{1'b1}};
        end else begin
            if (wr_data_en) begin
                data <= wdata; // [R10]
            end
            if (wr_dir_en) begin
                dir <= wdata; // [R10]
            end
        end
    end

    // ======================================================================
    // Pad drive.
    // ======================================================================
    // An open-drain pin only ever pulls low: its enable drops while the data
    // bit is one, and the driven level is then always zero.
    always @(posedge clk) begin
        if (!rst_b) begin
            pad_out <= {WIDTH{1'b0}};
            pad_oe <= {WIDTH{1'b0}};
        end else begin
            pad_out <= data & ~od; // [R2]
            pad_oe <= ~dir & ~(od & data); // [R2] [R10]
        end
    end

endmodule // pcfg_port

//--- core/pcfg_top.v
// Port pad configuration, direction control, interrupt masks and port 6 change wake-up.
//
// Operation
// (R1) Pull-down bits: 7..4 port6, 3..0 port5; zero enables.
// (R2) Open-drain bit n drives port6 pin n.
// (R3) Pull-high bit n, port6 pin n, zero enables.
// (R4) Configuration registers read back last written value.
// (R5) Mask two enables comparator, timers, uart sources.
// (R6) Software writes zero to mask two bit 6.
// (R7) Mask one enables adc, spi, pwm, ext, change, timer.
// (R8) Software writes zero to mask one bit 7.
// (R9) Service needs mask bit and global enable.
// (R10) Ports 5..8 tri-state, per-pin direction, registers readable.
// (R11) Software: read port6, enable, wake bit, sleep.
// (R12) Wake with global enable vectors to 006H, else next.
// (R13) Change enable clear: wake always continues at next.
// (R14) Awake change with enables set vectors to 006H.
// (R15) Change means pins differ from last read snapshot.
`include "pcfg_defs.vh"

module pcfg_top (
    // Clock and synchronous active-low reset.
    input wire CLK,
    input wire RST_B,
    // Avalon-MM slave, word addressed.
    input wire [4:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    // Port pins, taken as synchronous to CLK.
    input wire [7:0] P5_IN,
    input wire [7:0] P6_IN,
    input wire [7:0] P7_IN,
    input wire [7:0] P8_IN,
    output wire [7:0] P5_OUT,
    output wire [7:0] P5_OE,
    output wire [7:0] P6_OUT,
    output wire [7:0] P6_OE,
    output wire [7:0] P7_OUT,
    output wire [7:0] P7_OE,
    output wire [7:0] P8_OUT,
    output wire [7:0] P8_OE,
    // Pad resistor controls, active low where named so.
    output reg [7:0] PULLDOWN_N,
    output reg [7:0] PULLHIGH6_N,
    // Interrupt flags of the other peripherals.
    input wire [7:0] FLAG_ONE,
    input wire [7:0] FLAG_TWO,
    // Core-facing interrupt and wake-up results.
    output reg INT_REQ,
    output reg [11:0] INT_VECTOR,
    output reg WAKE,
    output reg WAKE_VECTOR,
    output reg SLEEPING,
    output reg IRQ
);

    // ======================================================================
    // Register storage.
    // ======================================================================
    reg [7:0] open_drain_ctrl; // Open-drain enables of port 6.
    reg [7:0] irq_mask_two; // Second interrupt mask.
    reg [7:0] irq_mask_one; // First interrupt mask.
    reg [7:0] wake_control_reg; // Wake-up enables.
    reg [7:0] evt_status; // Sticky block events, write one to clear.
    reg [7:0] evt_mask; // Gates events onto IRQ.
    reg global_irq_en; // Set by enable, cleared by disable command.
    reg [7:0] p6_snap; // Port 6 levels at the last software read.
    reg [31:0] next_readdata; // Read multiplexer output.

    // Port register contents.
    wire [7:0] p5_data, p6_data, p7_data, p8_data;
    wire [7:0] p5_dir, p6_dir, p7_dir, p8_dir;

    // ======================================================================
    // Bus handshake.
    // ======================================================================
    // A request is seen while waitrequest is high; waitrequest drops on the
    // next edge with the read data already loaded, and the access completes
    // at the edge where the master samples it low.
    wire req = AVS_READ | AVS_WRITE;
    wire done = req & ~AVS_WAITREQUEST;
    wire wr_done = AVS_WRITE & done & AVS_BYTEENABLE[0];
    wire [7:0] wbyte = AVS_WRITEDATA[7:0];

    always @(posedge CLK) begin
        if (!RST_B) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else if (req && AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA <= next_readdata;
        end else begin
            AVS_WAITREQUEST <= 1'b1;
        end
    end

    // One-hot write strobes by word index, kept as a net so every reader follows the address; indexes past 16 decode to nothing.
    wire [16:0] wr_sel = wr_done ? (17'h00001 << AVS_ADDRESS) : 17'h00000;

    // Reading port 6 completes here; it refreshes the change snapshot.
    wire p6_read = AVS_READ & done & (AVS_ADDRESS == `PCFG_IDX_P6_DATA);

    // ======================================================================
    // Read multiplexer.
    // ======================================================================
    // Data reads return the pin levels, as a port read does on the core.
    // Unmapped words read as zero and are still answered.
    always @* begin
        next_readdata = 32'h00000000;
        case (AVS_ADDRESS)
            `PCFG_IDX_PULLDOWN_TWO: next_readdata[7:0] = PULLDOWN_N; // [R4]
            `PCFG_IDX_OPEN_DRAIN: next_readdata[7:0] = open_drain_ctrl; // [R4]
            `PCFG_IDX_PULLHIGH_TWO: next_readdata[7:0] = PULLHIGH6_N; // [R4]
            `PCFG_IDX_IRQ_MASK_TWO: next_readdata[7:0] = irq_mask_two;
            `PCFG_IDX_IRQ_MASK_ONE: next_readdata[7:0] = irq_mask_one;
            `PCFG_IDX_P5_DATA: next_readdata[7:0] = P5_IN; // [R10]
            `PCFG_IDX_P6_DATA: next_readdata[7:0] = P6_IN; // [R10]
            `PCFG_IDX_P7_DATA: next_readdata[7:0] = P7_IN; // [R10]
            `PCFG_IDX_P8_DATA: next_readdata[7:0] = P8_IN; // [R10]
            `PCFG_IDX_P5_DIR: next_readdata[7:0] = p5_dir; // [R10]
            `PCFG_IDX_P6_DIR: next_readdata[7:0] = p6_dir; // [R10]
            `PCFG_IDX_P7_DIR: next_readdata[7:0] = p7_dir; // [R10]
            `PCFG_IDX_P8_DIR: next_readdata[7:0] = p8_dir; // [R10]
            `PCFG_IDX_WAKE_CTRL: next_readdata[7:0] = wake_control_reg;
            `PCFG_IDX_CORE_CMD: begin
                next_readdata[`PCFG_BIT_CMD_ENI] = global_irq_en;
                next_readdata[`PCFG_BIT_CMD_SLEEP] = SLEEPING;
            end
            `PCFG_IDX_EVT_STATUS: next_readdata[7:0] = evt_status;
            `PCFG_IDX_EVT_MASK: next_readdata[7:0] = evt_mask;
            default: next_readdata = 32'h00000000;
        endcase
    end

    // ======================================================================
    // Pad configuration registers.
    // ======================================================================
    // Pull controls go straight to the pads, open-drain through port 6's registered pad drive; a zero in a
    // pull register turns the resistor on.
    always @(posedge CLK) begin
        if (!RST_B) begin
            PULLDOWN_N <= `PCFG_RST_PULLDOWN;
            open_drain_ctrl <= `PCFG_RST_OPEN_DRAIN;
            PULLHIGH6_N <= `PCFG_RST_PULLHIGH;
        end else begin
            if (wr_sel[`PCFG_IDX_PULLDOWN_TWO]) begin
                PULLDOWN_N <= wbyte; // [R1] [R4]
            end
            if (wr_sel[`PCFG_IDX_OPEN_DRAIN]) begin
                open_drain_ctrl <= wbyte; // [R2] [R4]
            end
            if (wr_sel[`PCFG_IDX_PULLHIGH_TWO]) begin
                PULLHIGH6_N <= wbyte; // [R3] [R4]
            end
        end
    end

    // ======================================================================
    // Interrupt masks and wake control.
    // ======================================================================
    // The unused mask bits are not stored, so they always read as zero even
    // if software ignores its duty to write zero there.
    always @(posedge CLK) begin
        if (!RST_B) begin
            irq_mask_two <= `PCFG_RST_IRQ_MASK;
            irq_mask_one <= `PCFG_RST_IRQ_MASK;
            wake_control_reg <= `PCFG_RST_WAKE_CTRL;
            evt_mask <= 8'h00;
        end else begin
            if (wr_sel[`PCFG_IDX_IRQ_MASK_TWO]) begin
                irq_mask_two <= wbyte & `PCFG_MASK_TWO_USED; // [R5] [R6]
            end
            if (wr_sel[`PCFG_IDX_IRQ_MASK_ONE]) begin
                irq_mask_one <= wbyte & `PCFG_MASK_ONE_USED; // [R7] [R8]
            end
            if (wr_sel[`PCFG_IDX_WAKE_CTRL]) begin
                wake_control_reg <= wbyte;
            end
            if (wr_sel[`PCFG_IDX_EVT_MASK]) begin
                evt_mask <= wbyte & `PCFG_EVT_USED;
            end
        end
    end

    // ======================================================================
    // Port 6 input change detection.
    // ======================================================================
    // The snapshot is taken at the edge the read completes, one edge after
    // the read data was loaded, so software and the comparison see samples one cycle apart.
    wire p6_change = (P6_IN != p6_snap); // [R15]

    always @(posedge CLK) begin
        if (!RST_B) begin
            p6_snap <= 8'h00;
        end else if (p6_read) begin
            p6_snap <= P6_IN; // [R11] [R15]
        end
    end

    // ======================================================================
    // Global enable and sleep state.
    // ======================================================================
    wire cmd_wr = wr_sel[`PCFG_IDX_CORE_CMD];
    wire input_change_irq_en = irq_mask_one[`PCFG_BIT_INPUT_CHANGE_IE];
    wire wake_now = SLEEPING & p6_change & wake_control_reg[`PCFG_BIT_WAKE_ENABLE];

    // Disable wins when both commands arrive in one write, the safer choice.
    always @(posedge CLK) begin
        if (!RST_B) begin
            global_irq_en <= 1'b0;
            SLEEPING <= 1'b0;
            WAKE <= 1'b0;
            WAKE_VECTOR <= 1'b0;
        end else begin
            if (cmd_wr && wbyte[`PCFG_BIT_CMD_GLOBAL_IRQ_OFF_INSTR]) begin
                global_irq_en <= 1'b0; // [R9]
            end else if (cmd_wr && wbyte[`PCFG_BIT_CMD_ENI]) begin
                global_irq_en <= 1'b1; // [R9]
            end
            // Waking takes priority over a fresh sleep command.
            if (wake_now) begin
                SLEEPING <= 1'b0;
            end else if (cmd_wr && wbyte[`PCFG_BIT_CMD_SLEEP]) begin
                SLEEPING <= 1'b1; // [R11]
            end
            // Branch to the vector only with both enables; else resume next.
            WAKE <= wake_now;
            WAKE_VECTOR <= wake_now & global_irq_en & input_change_irq_en; // [R12] [R13]
        end
    end

    // ======================================================================
    // Block events, status and interrupt line.
    // ======================================================================
    // A set in the same cycle as a write-one clear wins, so no event is lost.
    wire [7:0] evt_set = {6'h00, wake_now, p6_change};
    wire [7:0] evt_clr = wr_sel[`PCFG_IDX_EVT_STATUS] ? wbyte : 8'h00;

    always @(posedge CLK) begin
        if (!RST_B) begin
            evt_status <= 8'h00;
            IRQ <= 1'b0;
        end else begin
            evt_status <= ((evt_status & ~evt_clr) | evt_set) & `PCFG_EVT_USED; // [R15]
            IRQ <= |(evt_status & evt_mask);
        end
    end

    // ======================================================================
    // Core interrupt request.
    // ======================================================================
    // Bit 1 of the first flag group is this block's own change flag; the
    // incoming bit there is ignored. Sleep suppresses the request: a wake
    // reports its destination through the wake outputs instead.
    wire [7:0] flags_one = {FLAG_ONE[7:2], evt_status[`PCFG_BIT_EVT_CHANGE], FLAG_ONE[0]};
    wire pending = (|(flags_one & irq_mask_one)) | (|(FLAG_TWO & irq_mask_two)); // [R5] [R7]
    wire next_int_req = global_irq_en & pending & ~SLEEPING; // [R9] [R14]

    always @(posedge CLK) begin
        if (!RST_B) begin
            INT_REQ <= 1'b0;
            INT_VECTOR <= 12'h000;
        end else begin
            INT_REQ <= next_int_req;
            INT_VECTOR <= next_int_req ? `PCFG_ICHG_VECTOR : 12'h000; // [R14]
        end
    end

    // ======================================================================
    // Ports 5 to 8.
    // ======================================================================
    pcfg_port #(.WIDTH(8)) u_port5 (
        .clk(CLK), .rst_b(RST_B),
        .wr_data_en(wr_sel[`PCFG_IDX_P5_DATA]), .wr_dir_en(wr_sel[`PCFG_IDX_P5_DIR]),
        .wdata(wbyte), .od(8'h00),
        .data(p5_data), .dir(p5_dir), .pad_out(P5_OUT), .pad_oe(P5_OE)
    );

    pcfg_port #(.WIDTH(8)) u_port6 (
        .clk(CLK), .rst_b(RST_B),
        .wr_data_en(wr_sel[`PCFG_IDX_P6_DATA]), .wr_dir_en(wr_sel[`PCFG_IDX_P6_DIR]),
        .wdata(wbyte), .od(open_drain_ctrl),
        .data(p6_data), .dir(p6_dir), .pad_out(P6_OUT), .pad_oe(P6_OE)
    );

    pcfg_port #(.WIDTH(8)) u_port7 (
        .clk(CLK), .rst_b(RST_B),
        .wr_data_en(wr_sel[`PCFG_IDX_P7_DATA]), .wr_dir_en(wr_sel[`PCFG_IDX_P7_DIR]),
        .wdata(wbyte), .od(8'h00),
        .data(p7_data), .dir(p7_dir), .pad_out(P7_OUT), .pad_oe(P7_OE)
    );

    pcfg_port #(.WIDTH(8)) u_port8 (
        .clk(CLK), .rst_b(RST_B),
        .wr_data_en(wr_sel[`PCFG_IDX_P8_DATA]), .wr_dir_en(wr_sel[`PCFG_IDX_P8_DIR]),
        .wdata(wbyte), .od(8'h00),
        .data(p8_data), .dir(p8_dir), .pad_out(P8_OUT), .pad_oe(P8_OE)
    );

endmodule // pcfg_top

//--- verification/pcfg_pins.sv
// Behavioural model of the circuits on the port pins.
module pcfg_pins (
    // Clock.
    input wire logic clk,
    // Pad drive, ports 5 to 8 packed low to high.
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    // Resistor controls, active low.
    input wire logic [7:0] pd_n,
    input wire logic [7:0] ph6_n,
    // Outside driver on port 6.
    input wire logic [7:0] ext6,
    input wire logic [7:0] ext6_en,
    // Resolved pin levels.
    output logic [31:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Last levels; a floating pin shows their inverse so no stale value passes.
    logic [31:0] last = '0;
    always @(posedge clk) last <= pin;
    // Own drive wins, then the outside driver, then a pull, then float.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pad_oe[i]) pin[i] = pad_out[i];
            else if (i / 8 == 1 && ext6_en[i % 8]) pin[i] = ext6[i % 8];
            else if (i / 8 == 1 && !ph6_n[i % 8]) pin[i] = 1'b1;
            else if ((i < 4 && !pd_n[i]) || (i / 8 == 1 && i % 8 < 4 && !pd_n[i - 4])) pin[i] = 1'b0;
            else pin[i] = ~last[i];
        end
    end
endmodule // pcfg_pins

//--- verification/pcfg_top_asserts.sv
// Concurrent checks on the port pad configuration block.
module pcfg_top_asserts (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_B,
    // Register bus.
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Pads and core results.
    input wire logic [7:0] P5_OE,
    input wire logic [7:0] PULLDOWN_N,
    input wire logic [7:0] PULLHIGH6_N,
    input wire logic INT_REQ,
    input wire logic [11:0] INT_VECTOR,
    input wire logic WAKE,
    input wire logic SLEEPING
);
    timeunit 1ns;
    timeprecision 1ps;
    // A write completing at this edge with byte lane 0 on.
    logic wr_done;
    assign wr_done = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // ==========================================================
    // Bus handshake and register effects.
    // ==========================================================
    wait_once_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered after one wait cycle");
    wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("wait release lasted more than one cycle");
    pd_write_a: assert property (wr_done && AVS_ADDRESS == 5'h00 |=> PULLDOWN_N == $past(AVS_WRITEDATA[7:0]))
        else $error("pull-down pins differ from written value");
    ph_write_a: assert property (wr_done && AVS_ADDRESS == 5'h02 |=> PULLHIGH6_N == $past(AVS_WRITEDATA[7:0]))
        else $error("pull-high pins differ from written value");
    dir_pad_a: assert property (wr_done && AVS_ADDRESS == 5'h09 |-> ##2 P5_OE == ~$past(AVS_WRITEDATA[7:0], 2))
        else $error("port 5 drive enable does not follow direction");
    // ==========================================================
    // Interrupt and wake-up results.
    // ==========================================================
    vec_match_a: assert property (INT_VECTOR == (INT_REQ ? 12'h006 : 12'h000))
        else $error("interrupt vector wrong");
    wake_exit_a: assert property (WAKE |-> !SLEEPING && $past(SLEEPING))
        else $error("wake pulse without leaving sleep");
    wake_pulse_a: assert property (WAKE |=> !WAKE)
        else $error("wake pulse longer than one cycle");
    sleep_quiet_a: assert property (SLEEPING && $past(SLEEPING) |-> !INT_REQ)
        else $error("interrupt requested while asleep");
endmodule // pcfg_top_asserts

bind pcfg_top pcfg_top_asserts pcfg_top_asserts_inst (.CLK(CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .P5_OE(P5_OE), .PULLDOWN_N(PULLDOWN_N),
    .PULLHIGH6_N(PULLHIGH6_N), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR), .WAKE(WAKE), .SLEEPING(SLEEPING));

//--- verification/pcfg_top_bench.sv
// Self-checking bench of the port pad configuration block.
`define CHK(nm, e, g) begin checked++; \
    if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module pcfg_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals, block and pin model.
    // ==========================================================
    logic clk = 1'b0;
    logic rst_b, rd, wr, int_req, wake, wake_vec, sleeping, irq, wait_req;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, pin_in;
    logic [3:0] be;
    logic [7:0] flag_one, flag_two, ext6, ext6_en, pd_n, ph6_n, rdv;
    logic [11:0] int_vec;
    wire [31:0] pad_out, pad_oe;
    int mismatches = 0;
    int checked = 0;
    pcfg_top pcfg_top_inst (.CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .P5_IN(pin_in[7:0]), .P6_IN(pin_in[15:8]), .P7_IN(pin_in[23:16]), .P8_IN(pin_in[31:24]),
        .P5_OUT(pad_out[7:0]), .P5_OE(pad_oe[7:0]), .P6_OUT(pad_out[15:8]), .P6_OE(pad_oe[15:8]),
        .P7_OUT(pad_out[23:16]), .P7_OE(pad_oe[23:16]), .P8_OUT(pad_out[31:24]), .P8_OE(pad_oe[31:24]),
        .PULLDOWN_N(pd_n), .PULLHIGH6_N(ph6_n), .FLAG_ONE(flag_one), .FLAG_TWO(flag_two), .INT_REQ(int_req),
        .INT_VECTOR(int_vec), .WAKE(wake), .WAKE_VECTOR(wake_vec), .SLEEPING(sleeping), .IRQ(irq));
    pcfg_pins pcfg_pins_inst (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pd_n(pd_n), .ph6_n(ph6_n),
        .ext6(ext6), .ext6_en(ext6_en), .pin(pin_in));
    initial forever #20 clk = ~clk;
    // ==========================================================
    // Bus tasks: hold the request until wait is seen low.
    // ==========================================================
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] b);
        @(posedge clk);
        {addr, wr, rd, wdata, be} <= {a, w, !w, 24'h0, d, b};
        do @(posedge clk); while (wait_req !== 1'b0);
        rdv = rdata[7:0];
        {wr, rd} <= 2'b00;
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] d); bus(1'b1, a, d, 4'hF); endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'hF);
        `CHK($sformatf("reg %0h", a), e, rdv);
    endtask
    task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
    // ==========================================================
    // Scenarios.
    // ==========================================================
    // Reset values, read-back, lane-off write and an unmapped place.
    task automatic t_regs();
        logic [7:0] rv [5] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
        logic [7:0] wv [5] = '{8'h5A, 8'hA5, 8'hC3, 8'hBF, 8'h7F};
        for (int i = 0; i < 5; i++) rchk(5'(i), rv[i]);
        `CHK("pulldown pins", 8'hFF, pd_n);
        for (int i = 0; i < 5; i++) wreg(5'(i), wv[i]);
        for (int i = 0; i < 5; i++) rchk(5'(i), wv[i]);
        `CHK("pulldown pins", 8'h5A, pd_n);
        `CHK("pullhigh pins", 8'hC3, ph6_n);
        bus(1'b1, 5'h00, 8'h00, 4'h0);
        rchk(5'h00, 8'h5A);
        rchk(5'h1F, 8'h00);
        $display("test regs done");
    endtask
    // Direction and data of every port, then open-drain on port 6.
    task automatic t_ports();
        for (int p = 0; p < 4; p++) begin
            wreg(5'(9 + p), 8'h0F);
            wreg(5'(5 + p), 8'h50);
            cyc(2);
            `CHK("pad enable", 8'hF0, pad_oe[p*8 +: 8]);
            `CHK("pad level", 8'h50, pad_out[p*8 +: 8] & pad_oe[p*8 +: 8]);
        end
        rchk(5'h09, 8'h0F);
        wreg(5'h0A, 8'h00);
        wreg(5'h06, 8'h0F);
        cyc(2);
        `CHK("drain enable", 8'hFA, pad_oe[15:8]);
        `CHK("drain level", 8'h0A, pad_out[15:8] & pad_oe[15:8]);
        wreg(5'h0A, 8'hFF);
        $display("test ports done");
    endtask
    // Each used mask bit except the change enable gates its flag; disable wins over enable.
    task automatic t_irq();
        wreg(5'h04, 8'h00);
        wreg(5'h03, 8'h00);
        wreg(5'h0E, 8'h01);
        for (int j = 0; j < 16; j++) begin
            if (j == 6 || j == 9 || j == 15) continue;
            {flag_one, flag_two} <= 16'h0001 << j;
            wreg(j < 8 ? 5'h03 : 5'h04, 8'h01 << (j % 8));
            cyc(2);
            `CHK("unmasked request", 1'b1, int_req);
            wreg(j < 8 ? 5'h03 : 5'h04, 8'h00);
            cyc(2);
            `CHK("masked request", 1'b0, int_req);
        end
        {flag_one, flag_two} <= 16'h0001;
        wreg(5'h03, 8'h01);
        wreg(5'h0E, 8'h03);
        cyc(2);
        `CHK("global off", 1'b0, int_req);
        wreg(5'h03, 8'h00);
        flag_two <= 8'h00;
        $display("test irq done");
    endtask
    // Awake change interrupt against the read snapshot.
    task automatic t_change();
        {ext6_en, ext6} <= 16'hFF00;
        rchk(5'h06, 8'h00);
        wreg(5'h0F, 8'h03);
        wreg(5'h10, 8'h01);
        wreg(5'h04, 8'h02);
        wreg(5'h0E, 8'h01);
        cyc(2);
        `CHK("quiet request", 1'b0, int_req);
        ext6 <= 8'h10;
        cyc(4);
        `CHK("change request", 1'b1, int_req);
        `CHK("change vector", 12'h006, int_vec);
        `CHK("change status", 1'b1, irq);
        rchk(5'h0F, 8'h01);
        rchk(5'h10, 8'h01);
        ext6 <= 8'h00;
        wreg(5'h0F, 8'h01);
        cyc(3);
        `CHK("cleared status", 1'b0, irq);
        wreg(5'h0E, 8'h02);
        $display("test change done");
    endtask
    // Sleep and wake with global on, global off, change enable off.
    task automatic t_wake();
        logic [7:0] cmd [3] = '{8'h01, 8'h02, 8'h01};
        logic [7:0] msk [3] = '{8'h02, 8'h02, 8'h00};
        logic exv [3] = '{1'b1, 1'b0, 1'b0};
        int n;
        for (int k = 0; k < 3; k++) begin
            rchk(5'h06, 8'h00);
            wreg(5'h0F, 8'h03);
            wreg(5'h0E, cmd[k]);
            wreg(5'h04, msk[k]);
            wreg(5'h0D, 8'h40);
            wreg(5'h0E, 8'h04);
            cyc(2);
            `CHK("sleep state", 1'b1, sleeping);
            rchk(5'h0E, 8'h04 | (cmd[k] & 8'h01));
            rchk(5'h0D, 8'h40);
            ext6 <= 8'h81;
            n = 0;
            do begin @(posedge clk); n++; end while (wake !== 1'b1 && n < 10);
            `CHK("wake pulse", 1'b1, wake);
            `CHK("wake target", exv[k], wake_vec);
            ext6 <= 8'h00;
        end
        $display("test wake done");
    endtask
    // Verdict and end of run.
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence after two reset cycles.
    initial begin
        {rst_b, rd, wr, addr, wdata, be, flag_one, flag_two, ext6, ext6_en} <= '0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_ports();
        t_irq();
        t_change();
        t_wake();
        complete_run();
    end
    // A hang is cut short well past the expected run length.
    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        $display("timeout reached");
        complete_run();
    end
endmodule // pcfg_top_bench
